// ===== rtl/dcfs_consts.svh
// Offsets, field positions, reset values and timing figures of the discharge supervisor.
`ifndef DCFS_CONSTS_SVH
`define DCFS_CONSTS_SVH
`define DCFS_CLK_KHZ 25000
`define DCFS_DEB_MS 16
`define DCFS_UV_SET_MS 32
`define DCFS_UV_CLR_MS 64
`define DCFS_OFS_CTRL 8'h00
`define DCFS_OFS_VOUT 8'h04
`define DCFS_OFS_ILIM 8'h08
`define DCFS_OFS_UVLO 8'h0C
`define DCFS_OFS_STAT 8'h10
`define DCFS_B_DIS_EN 0
`define DCFS_B_FB_MODE 1
`define DCFS_B_THERM_EN 2
`define DCFS_F_DIE_SEL 4
`define DCFS_F_CHG_LO 6
`define DCFS_F_CHG_HI 8
`define DCFS_F_DIS_LO 10
`define DCFS_F_DIS_HI 12
`define DCFS_F_BIAS 14
`define DCFS_F_IBAT 8
`define DCFS_F_UV_HYS 8
`define DCFS_CTRL_RST 32'h0000_0004
`define DCFS_VOUT_RST 32'h0000_0000
`define DCFS_ILIM_RST 32'h0000_0000
`define DCFS_UVLO_RST 32'h0000_0005
`define DCFS_UV_THR_RST 7'h05
`define DCFS_VOUT_BASE 16'h0BB8
`define DCFS_VOUT_STEP 16'h000A
`define DCFS_VOUT_MAX 16'h55F0
`define DCFS_IBUS_BASE 16'h01F4
`define DCFS_IBUS_STEP 16'h0032
`define DCFS_IBAT_BASE 16'h0064
`define DCFS_IBAT_STEP 16'h0064
`define DCFS_IBAT_MAX 16'h2EE0
`define DCFS_UV_BASE 16'h09C4
`define DCFS_UV_STEP 16'h0064
`define DCFS_UV_MAX 16'h3390
`define DCFS_HYS_BASE 16'h0190
`define DCFS_HYS_STEP 16'h0064
`define DCFS_NO_MAX 16'hFFFF
`define DCFS_DIE_HYS 9'sh014
`define DCFS_NTC_HYS 9'sh005
`define DCFS_OVP_FB_TRIP 24'h5DC0
`define DCFS_OVP_FB_EXIT 24'h58D4
`define DCFS_OVP_TRIP_PCT 24'h000070
`define DCFS_OVP_EXIT_PCT 24'h00006A
`define DCFS_PCT_SCALE 24'h000064
`endif

// ===== rtl/dcfs_pkg.sv
// Types shared by the discharge supervisor modules.
package dcfs_pkg;
	typedef enum logic [0:0] {DCFS_CLEAR = 1'b0, DCFS_TRIP = 1'b1} dcfs_dbst_t;
	typedef logic signed [8:0] dcfs_temp_t;
endpackage

// ===== rtl/dcfs_dbnc_if.sv
// Condition and flag bundle between the supervisor and one debounce filter.
`timescale 1ns/10ps
interface dcfs_dbnc_if;
	logic set_cond;
	logic clr_cond;
	logic flag;
	modport ctl(output set_cond, output clr_cond, input flag);
	modport flt(input set_cond, input clr_cond, output flag);
endinterface

// ===== rtl/dcfs_debounce.sv
// Entry and exit debounce filter that latches one protection event.
`timescale 1ns/10ps
module dcfs_debounce #(
	parameter int CW = 24,
	parameter int SET_CYC = 400000,
	parameter int CLR_CYC = 400000
) (
	input wire logic clk,
	input wire logic rst,
	dcfs_dbnc_if.flt dbi
);
	dcfs_pkg::dcfs_dbst_t state;
	logic [CW-1:0] cnt;

	// A condition that drops before its time runs out starts the wait over.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= dcfs_pkg::DCFS_CLEAR;
			cnt <= '0;
		end
		else
		begin
			unique case (state)
				dcfs_pkg::DCFS_CLEAR:
				begin
					if (!dbi.set_cond)
						cnt <= '0;
					else if (cnt == CW'(SET_CYC - 1))
					begin
						state <= dcfs_pkg::DCFS_TRIP;
						cnt <= '0;
					end
					else
						cnt <= cnt + 1'b1;
				end
				dcfs_pkg::DCFS_TRIP:
				begin
					if (!dbi.clr_cond)
						cnt <= '0;
					else if (cnt == CW'(CLR_CYC - 1))
					begin
						state <= dcfs_pkg::DCFS_CLEAR;
						cnt <= '0;
					end
					else
						cnt <= cnt + 1'b1;
				end
			endcase
		end
	end

	always_comb dbi.flag = (state == dcfs_pkg::DCFS_TRIP);

	a_dbnc_entry_time: assert property (@(posedge clk) disable iff (rst)
		$rose(dbi.flag) |-> $past(dbi.set_cond) && ($past(cnt) == CW'(SET_CYC - 1)))
		else $error("Event latched without the full entry delay.");
	a_dbnc_restart: assert property (@(posedge clk) disable iff (rst)
		(state == dcfs_pkg::DCFS_CLEAR && !dbi.set_cond) |=> !dbi.flag && cnt == '0)
		else $error("Entry count kept running after the condition dropped.");
endmodule

// ===== rtl/dcfs_top.sv
// Discharge configuration decode and protection supervisor with an AXI4-Lite register port.
`timescale 1ns/10ps
`include "dcfs_consts.svh"
module dcfs_top #(
	parameter int ADDR_W = 8,
	parameter int DEB_CYC = `DCFS_DEB_MS * `DCFS_CLK_KHZ,
	parameter int UV_SET_CYC = `DCFS_UV_SET_MS * `DCFS_CLK_KHZ,
	parameter int UV_CLR_CYC = `DCFS_UV_CLR_MS * `DCFS_CLK_KHZ
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	input wire logic signed [8:0] DIE_TEMP_C,
	input wire logic signed [8:0] BAT_TEMP_C,
	input wire logic [15:0] VBUS_MV,
	input wire logic [15:0] VBAT_MV,
	input wire logic CHG_ACTIVE,
	output logic DIS_OUT_EN,
	output logic CONV_HALT,
	output logic CELL_PATH_SWITCH_ON,
	output logic FEEDBACK_PIN_REG,
	output logic [14:0] VOUT_SET_MV,
	output logic [12:0] IBUS_LIM_MA,
	output logic [13:0] IBAT_LIM_MA,
	output logic [13:0] UV_THR_MV,
	output logic [9:0] UV_HYS_MV,
	output logic [6:0] THERMISTOR_PIN_BIAS_UA
);
	localparam int CW = 24;

	logic [31:0] ctrl;
	logic [31:0] vout;
	logic [31:0] ilim;
	logic [31:0] uvlo;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] stat;
	logic [31:0] next_rdata;
	logic next_rerr;
	logic dis_en;
	logic fb_mode;
	logic therm_en;
	dcfs_pkg::dcfs_temp_t die_thr;
	dcfs_pkg::dcfs_temp_t chg_lo;
	dcfs_pkg::dcfs_temp_t chg_hi;
	dcfs_pkg::dcfs_temp_t dis_lo;
	dcfs_pkg::dcfs_temp_t dis_hi;
	logic [23:0] vbus_pct;
	logic [23:0] vout_trip;
	logic [23:0] vout_exit;
	logic ovp_over;
	logic ovp_under;
	logic [15:0] uv_rel;

	dcfs_dbnc_if die_if ();
	dcfs_dbnc_if chg_if ();
	dcfs_dbnc_if dis_if ();
	dcfs_dbnc_if ovp_if ();
	dcfs_dbnc_if uv_if ();

	function automatic logic [15:0] lin_dec(input logic [10:0] code, input logic [15:0] base,
		input logic [15:0] step, input logic [15:0] cap);
		logic [31:0] v;
		v = 32'(base) + 32'(step) * 32'(code);
		lin_dec = (v > 32'(cap)) ? cap : v[15:0];
	endfunction

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = dat[8*i +: 8];
		strb_merge = r;
	endfunction

	function automatic dcfs_pkg::dcfs_temp_t pick4(input logic [1:0] sel,
		input dcfs_pkg::dcfs_temp_t t0, input dcfs_pkg::dcfs_temp_t t1,
		input dcfs_pkg::dcfs_temp_t t2, input dcfs_pkg::dcfs_temp_t t3);
		unique case (sel)
			2'h0: pick4 = t0;
			2'h1: pick4 = t1;
			2'h2: pick4 = t2;
			2'h3: pick4 = t3;
		endcase
	endfunction

	assign dis_en = ctrl[`DCFS_B_DIS_EN];
	assign fb_mode = ctrl[`DCFS_B_FB_MODE];
	assign therm_en = ctrl[`DCFS_B_THERM_EN];

	// Threshold selections.
	always_comb
	begin
		die_thr = pick4(ctrl[`DCFS_F_DIE_SEL +: 2], 9'sh078, 9'sh082, 9'sh08C, 9'sh096);
		chg_lo = pick4(ctrl[`DCFS_F_CHG_LO +: 2], 9'sh00A, 9'sh005, 9'sh000, -9'sh005);
		chg_hi = pick4(ctrl[`DCFS_F_CHG_HI +: 2], 9'sh028, 9'sh02D, 9'sh032, 9'sh037);
		dis_lo = pick4(ctrl[`DCFS_F_DIS_LO +: 2], -9'sh014, -9'sh00A, -9'sh005, 9'sh000);
		dis_hi = pick4(ctrl[`DCFS_F_DIS_HI +: 2], 9'sh032, 9'sh037, 9'sh03C, 9'sh041);
	end

	// Register-mode overvoltage levels are compared in hundredths to avoid a divider.
	always_comb
	begin
		vbus_pct = 24'(VBUS_MV) * `DCFS_PCT_SCALE;
		vout_trip = 24'(VOUT_SET_MV) * `DCFS_OVP_TRIP_PCT;
		vout_exit = 24'(VOUT_SET_MV) * `DCFS_OVP_EXIT_PCT;
		if (fb_mode)
		begin
			ovp_over = 24'(VBUS_MV) > `DCFS_OVP_FB_TRIP;
			ovp_under = 24'(VBUS_MV) < `DCFS_OVP_FB_EXIT;
		end
		else
		begin
			ovp_over = vbus_pct > vout_trip;
			ovp_under = vbus_pct < vout_exit;
		end
		uv_rel = 16'(UV_THR_MV) + 16'(UV_HYS_MV);
	end

	// Protection conditions feeding the debounce filters.
	always_comb
	begin
		die_if.set_cond = DIE_TEMP_C >= die_thr;
		die_if.clr_cond = DIE_TEMP_C <= die_thr - `DCFS_DIE_HYS;
		chg_if.set_cond = therm_en && CHG_ACTIVE && (BAT_TEMP_C < chg_lo || BAT_TEMP_C > chg_hi);
		chg_if.clr_cond = !therm_en || (BAT_TEMP_C >= chg_lo + `DCFS_NTC_HYS
			&& BAT_TEMP_C <= chg_hi - `DCFS_NTC_HYS);
		dis_if.set_cond = therm_en && dis_en && (BAT_TEMP_C < dis_lo || BAT_TEMP_C > dis_hi);
		dis_if.clr_cond = !therm_en || (BAT_TEMP_C >= dis_lo + `DCFS_NTC_HYS
			&& BAT_TEMP_C <= dis_hi - `DCFS_NTC_HYS);
		ovp_if.set_cond = dis_en && ovp_over;
		ovp_if.clr_cond = !dis_en || ovp_under;
		uv_if.set_cond = dis_en && VBAT_MV < 16'(UV_THR_MV);
		uv_if.clr_cond = !dis_en || VBAT_MV > uv_rel;
	end

	dcfs_debounce #(.CW(CW), .SET_CYC(DEB_CYC), .CLR_CYC(DEB_CYC)) u_die (
		.clk(CORE_CLK), .rst(RST), .dbi(die_if.flt));
	dcfs_debounce #(.CW(CW), .SET_CYC(DEB_CYC), .CLR_CYC(DEB_CYC)) u_chg (
		.clk(CORE_CLK), .rst(RST), .dbi(chg_if.flt));
	dcfs_debounce #(.CW(CW), .SET_CYC(DEB_CYC), .CLR_CYC(DEB_CYC)) u_dis (
		.clk(CORE_CLK), .rst(RST), .dbi(dis_if.flt));
	dcfs_debounce #(.CW(CW), .SET_CYC(DEB_CYC), .CLR_CYC(DEB_CYC)) u_ovp (
		.clk(CORE_CLK), .rst(RST), .dbi(ovp_if.flt));
	dcfs_debounce #(.CW(CW), .SET_CYC(UV_SET_CYC), .CLR_CYC(UV_CLR_CYC)) u_uv (
		.clk(CORE_CLK), .rst(RST), .dbi(uv_if.flt));

	// Decoded settings and protection outputs, one cycle behind the registers.
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			VOUT_SET_MV <= 15'h0BB8;
			IBUS_LIM_MA <= 13'h01F4;
			IBAT_LIM_MA <= 14'h0064;
			UV_THR_MV <= 14'h0BB8;
			UV_HYS_MV <= 10'h190;
			FEEDBACK_PIN_REG <= 1'b0;
			THERMISTOR_PIN_BIAS_UA <= 7'h50;
			DIS_OUT_EN <= 1'b0;
			CONV_HALT <= 1'b0;
			CELL_PATH_SWITCH_ON <= 1'b1;
		end
		else
		begin
			VOUT_SET_MV <= 15'(lin_dec(vout[10:0], `DCFS_VOUT_BASE, `DCFS_VOUT_STEP,
				`DCFS_VOUT_MAX));
			IBUS_LIM_MA <= 13'(lin_dec({4'h0, ilim[6:0]}, `DCFS_IBUS_BASE, `DCFS_IBUS_STEP,
				`DCFS_NO_MAX));
			IBAT_LIM_MA <= 14'(lin_dec({4'h0, ilim[`DCFS_F_IBAT +: 7]}, `DCFS_IBAT_BASE,
				`DCFS_IBAT_STEP, `DCFS_IBAT_MAX));
			UV_THR_MV <= 14'(lin_dec({4'h0, uvlo[6:0]}, `DCFS_UV_BASE, `DCFS_UV_STEP,
				`DCFS_UV_MAX));
			UV_HYS_MV <= 10'(lin_dec({9'h000, uvlo[`DCFS_F_UV_HYS +: 2]}, `DCFS_HYS_BASE,
				`DCFS_HYS_STEP, `DCFS_NO_MAX));
			FEEDBACK_PIN_REG <= fb_mode;
			unique case (ctrl[`DCFS_F_BIAS +: 2])
				2'h0: THERMISTOR_PIN_BIAS_UA <= 7'h50;
				2'h1: THERMISTOR_PIN_BIAS_UA <= 7'h28;
				2'h2: THERMISTOR_PIN_BIAS_UA <= 7'h14;
				2'h3: THERMISTOR_PIN_BIAS_UA <= 7'h14;
			endcase
			// The output needs the enable and no latched discharge-side fault, in either mode.
			DIS_OUT_EN <= dis_en && !die_if.flag && !dis_if.flag && !ovp_if.flag
				&& !uv_if.flag;
			CONV_HALT <= die_if.flag || dis_if.flag;
			CELL_PATH_SWITCH_ON <= !chg_if.flag;
		end
	end

	assign stat = {24'h000000, CELL_PATH_SWITCH_ON, CONV_HALT, DIS_OUT_EN, uv_if.flag,
		ovp_if.flag, dis_if.flag, chg_if.flag, die_if.flag};

	// Write path: address and data are taken in either order, then committed together.
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			BVALID <= 1'b0;
			BRESP <= 2'h0;
			wr_addr <= '0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				wr_addr <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY)
			begin
				wr_data <= WDATA;
				wr_strb <= WSTRB;
				WREADY <= 1'b0;
			end
			if (!AWREADY && !WREADY && !BVALID)
			begin
				BVALID <= 1'b1;
				BRESP <= (wr_addr > ADDR_W'(`DCFS_OFS_STAT) || wr_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end
			if (BVALID && BREADY)
			begin
				BVALID <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	// Settings registers; the undervoltage threshold starts at its 3.0 V code.
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			ctrl <= `DCFS_CTRL_RST;
			vout <= `DCFS_VOUT_RST;
			ilim <= `DCFS_ILIM_RST;
			uvlo <= `DCFS_UVLO_RST;
		end
		else if (!AWREADY && !WREADY && !BVALID)
		begin
			unique case (wr_addr)
				ADDR_W'(`DCFS_OFS_CTRL): ctrl <= strb_merge(ctrl, wr_data, wr_strb) & 32'h0000_FFF7;
				ADDR_W'(`DCFS_OFS_VOUT): vout <= strb_merge(vout, wr_data, wr_strb) & 32'h0000_07FF;
				ADDR_W'(`DCFS_OFS_ILIM): ilim <= strb_merge(ilim, wr_data, wr_strb) & 32'h0000_7F7F;
				ADDR_W'(`DCFS_OFS_UVLO): uvlo <= strb_merge(uvlo, wr_data, wr_strb) & 32'h0000_037F;
				default:
				begin
				end
			endcase
		end
	end

	always_comb
	begin
		next_rerr = 1'b0;
		unique case (ARADDR)
			ADDR_W'(`DCFS_OFS_CTRL): next_rdata = ctrl;
			ADDR_W'(`DCFS_OFS_VOUT): next_rdata = vout;
			ADDR_W'(`DCFS_OFS_ILIM): next_rdata = ilim;
			ADDR_W'(`DCFS_OFS_UVLO): next_rdata = uvlo;
			ADDR_W'(`DCFS_OFS_STAT): next_rdata = stat;
			default:
			begin
				next_rdata = 32'h0000_0000;
				next_rerr = 1'b1;
			end
		endcase
	end

	// Read path: data are captured at the address handshake.
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= 2'h0;
		end
		else if (ARVALID && ARREADY)
		begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RDATA <= next_rdata;
			RRESP <= next_rerr ? 2'h2 : 2'h0;
		end
		else if (RVALID && RREADY)
		begin
			RVALID <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	a_vout_cap: assert property (vout[10:0] > 11'h076C |=> VOUT_SET_MV == 15'h55F0)
		else $error("Output voltage setting not held at its ceiling.");
	a_ibus_decode: assert property (##1 IBUS_LIM_MA
		== 13'(13'h01F4 + 13'h0032 * 13'($past(ilim[6:0]))))
		else $error("Bus current limit decode wrong.");
	a_ibat_cap: assert property (ilim[14:8] > 7'h76 |=> IBAT_LIM_MA == 14'h2EE0)
		else $error("Battery current limit not held at its ceiling.");
	a_uv_reset: assert property ($past(RST) |-> uvlo[6:0] == `DCFS_UV_THR_RST)
		else $error("Undervoltage threshold does not start at its default.");
	a_fb_mode: assert property (##1 FEEDBACK_PIN_REG == $past(fb_mode))
		else $error("Feedback pin regulation does not follow the mode.");
	a_out_gate: assert property (DIS_OUT_EN |-> $past(dis_en) && !$past(uv_if.flag))
		else $error("Discharge output on without enable or under a fault.");
	a_die_halt: assert property ($rose(die_if.flag) |=> CONV_HALT && !DIS_OUT_EN)
		else $error("Converter not halted after die fault.");
	a_path_keep: assert property (dis_if.flag && !chg_if.flag |=> CELL_PATH_SWITCH_ON)
		else $error("Cell path switch opened by a discharge temperature fault.");
	a_ovp_fb: assert property (fb_mode && VBUS_MV <= 16'h5DC0 && !ovp_if.flag |=> !ovp_if.flag)
		else $error("Overvoltage latched below the feedback mode trip level.");
endmodule

// ===== dv/dcfs_host.sv
// Host bus master model that programs the supervisor over AXI4-Lite.
`timescale 1ns/10ps
module dcfs_host (
	input wire logic clk,
	output logic awvalid,
	input wire logic awready,
	output logic [7:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [7:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	logic tmo = 1'b0;
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
	end
	// Each call starts one edge later, so the readies raised again at the last edge are high before the next request.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		r = 2'bXX;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		{awvalid, wvalid, bready} <= 3'h7;
		for (n = 0; n < 64; n++)
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		tmo = tmo | (n == 64);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		r = 2'bXX;
		d = 32'hXXXX_XXXX;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (n = 0; n < 64; n++)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		tmo = tmo | (n == 64);
	endtask
endmodule

// ===== dv/dcfs_top_tb.sv
// Self-checking bench for the discharge supervisor.
`timescale 1ns/10ps
`include "dcfs_consts.svh"
module dcfs_top_tb;
	localparam int DEB = 8;
	localparam int UVS = 16;
	localparam int UVC = 32;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr;
	logic [7:0] araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic [3:0] wstrb;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [1:0] rr;
	logic signed [8:0] die_t = 9'h019;
	logic signed [8:0] bat_t = 9'h019;
	logic [15:0] vbus = 16'h1388;
	logic [15:0] vbat = 16'h1F40;
	logic chg = 1'b0;
	logic dis_en, halt, path_on, fb_reg;
	logic [14:0] vout;
	logic [12:0] ibus;
	logic [13:0] ibat;
	logic [13:0] uvthr;
	logic [9:0] uvhys;
	logic [6:0] bias;
	int err_count = 0;
	int tests_run = 0;
	int i;
	int thr;
	int vc[4] = '{0, 1900, 1901, 2047};
	int lc[4] = '{0, 1, 119, 127};
	int uc[4] = '{0, 5, 106, 127};
	int bx[4] = '{80, 40, 20, 20};
	int cw[4] = '{5, 32'h1005, 32'h105, 32'hC5};
	int bad[4] = '{-21, 56, 46, -6};
	int okt[4] = '{-10, 45, 35, 5};
	int cl[4] = '{10, 5, 0, -5};
	int ch[4] = '{40, 45, 50, 55};
	int dl[4] = '{-20, -10, -5, 0};
	int dh[4] = '{50, 55, 60, 65};
	always #20 clk = ~clk;
	dcfs_top #(.DEB_CYC(DEB), .UV_SET_CYC(UVS), .UV_CLR_CYC(UVC)) i_dut (
		.CORE_CLK(clk), .RST(rst), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
		.WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid),
		.BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
		.ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
		.DIE_TEMP_C(die_t), .BAT_TEMP_C(bat_t), .VBUS_MV(vbus), .VBAT_MV(vbat),
		.CHG_ACTIVE(chg), .DIS_OUT_EN(dis_en), .CONV_HALT(halt), .CELL_PATH_SWITCH_ON(path_on),
		.FEEDBACK_PIN_REG(fb_reg), .VOUT_SET_MV(vout), .IBUS_LIM_MA(ibus), .IBAT_LIM_MA(ibat),
		.UV_THR_MV(uvthr), .UV_HYS_MV(uvhys), .THERMISTOR_PIN_BIAS_UA(bias));
	dcfs_host i_host (
		.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	function automatic int sat(input int b, input int st, input int c, input int cap);
		int v;
		v = b + st * c;
		return (v > cap) ? cap : v;
	endfunction
	task automatic final_report();
		$display("Summary: %0d checks, %0d errors", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic bus_hang();
		if (i_host.tmo)
		begin
			err_count++;
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		i_host.wr(a, d, rr);
		bus_hang();
		chk(rr, er, "bresp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		i_host.rd(a, rv, rr);
		bus_hang();
		chk(rr, er, "rresp");
		chk(rv, ed, "rdata");
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Waits out the filter count, then looks at dis_en (0) or halt (1).
	task automatic hold(input int n, input int sel, input logic exp, input string what);
		cyc(n);
		chk(sel ? halt : dis_en, exp, what);
	endtask
	// Moves the cell temperature, waits out the filter, then looks at halt and the path switch.
	task automatic tstep(input int t, input logic [1:0] exp, input string what);
		bat_t <= 9'(t);
		cyc(DEB + 3);
		chk({halt, path_on}, exp, what);
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		chk({vout, ibus}, {15'(3000), 13'(500)}, "reset vout ibus");
		chk({ibat, uvthr, uvhys}, {14'(100), 14'(3000), 10'(400)}, "reset uv");
		chk({bias, dis_en, halt, path_on, fb_reg}, {7'(80), 4'h2}, "reset outs");
		rd(`DCFS_OFS_CTRL, `DCFS_CTRL_RST, 2'h0);
		rd(`DCFS_OFS_UVLO, `DCFS_UVLO_RST, 2'h0);
		for (i = 0; i < 4; i++)
		begin
			wr(`DCFS_OFS_VOUT, vc[i], 2'h0);
			wr(`DCFS_OFS_ILIM, lc[i] << 8 | lc[3 - i], 2'h0);
			wr(`DCFS_OFS_UVLO, (uc[i] & 3) << 8 | uc[i], 2'h0);
			wr(`DCFS_OFS_CTRL, i << 14 | 4, 2'h0);
			cyc(2);
			chk(vout, sat(3000, 10, vc[i], 22000), "vout");
			chk(ibus, 500 + 50 * lc[3 - i], "ibus");
			chk(ibat, sat(100, 100, lc[i], 12000), "ibat");
			chk(uvthr, sat(2500, 100, uc[i], 13200), "uv thr");
			chk(uvhys, 400 + 100 * (uc[i] & 3), "uv hys");
			chk(bias, bx[i], "bias");
			rd(`DCFS_OFS_ILIM, lc[i] << 8 | lc[3 - i], 2'h0);
		end
		wr(8'h20, 32'h0000_00FF, 2'h2);
		wr(8'h06, 32'h0000_0001, 2'h2);
		rd(8'h20, 32'h0, 2'h2);
		wr(`DCFS_OFS_STAT, 32'h0000_00FF, 2'h0);
		rd(`DCFS_OFS_STAT, 32'h0000_0080, 2'h0);
		wr(`DCFS_OFS_VOUT, 500, 2'h0);
		wr(`DCFS_OFS_ILIM, 32'h0, 2'h0);
		wr(`DCFS_OFS_UVLO, 5, 2'h0);
		hold(3, 0, 1'b0, "off before enable");
		wr(`DCFS_OFS_CTRL, 32'h7, 2'h0);
		cyc(2);
		chk({dis_en, fb_reg}, 3, "feedback mode on");
		vbus <= 16'(24001);
		hold(DEB + 3, 0, 1'b0, "fixed trip");
		vbus <= 16'(22739);
		hold(DEB + 3, 0, 1'b1, "fixed exit");
		// The register-mode trip sits far lower, so the bus voltage drops first.
		vbus <= 16'(5000);
		wr(`DCFS_OFS_CTRL, 32'h5, 2'h0);
		cyc(2);
		chk({dis_en, fb_reg}, 2, "register mode on");
		vbus <= 16'(8961);
		hold(DEB + 3, 0, 1'b0, "ratio trip");
		vbus <= 16'(8479);
		hold(DEB + 3, 0, 1'b1, "ratio exit");
		vbat <= 16'(2999);
		cyc(UVS - 1);
		vbat <= 16'(8000);
		cyc(1);
		vbat <= 16'(2999);
		hold(UVS - 1, 0, 1'b1, "uv restart");
		hold(4, 0, 1'b0, "uv trip");
		vbat <= 16'(3401);
		hold(UVC + 3, 0, 1'b1, "uv exit");
		for (i = 0; i < 4; i++)
		begin
			thr = 120 + 10 * i;
			wr(`DCFS_OFS_CTRL, i << 4 | 5, 2'h0);
			die_t <= 9'(thr - 1);
			hold(DEB + 3, 1, 1'b0, "die below");
			die_t <= 9'(thr);
			hold(DEB + 3, 1, 1'b1, "die trip");
			die_t <= 9'(thr - 19);
			hold(DEB + 3, 1, 1'b1, "die warm");
			die_t <= 9'(thr - 21);
			hold(DEB + 3, 1, 1'b0, "die clear");
		end
		die_t <= 9'(150);
		cyc(DEB - 1);
		die_t <= 9'(25);
		cyc(1);
		die_t <= 9'(150);
		hold(DEB - 1, 1, 1'b0, "die restart");
		die_t <= 9'(25);
		for (i = 0; i < 4; i++)
		begin
			wr(`DCFS_OFS_CTRL, cw[i], 2'h0);
			chg <= (i > 1);
			bat_t <= 9'(bad[i]);
			cyc(DEB + 3);
			chk({halt, path_on}, (i < 2) ? 3 : 0, "cell temp trip");
			bat_t <= 9'(okt[i]);
			cyc(DEB + 3);
			chk({halt, path_on}, 1, "cell temp clear");
		end
		// With thermistor protection off, a cold cell must neither halt nor open the path.
		wr(`DCFS_OFS_CTRL, 32'h1, 2'h0);
		tstep(-30, 2'h1, "protection off");
		for (i = 0; i < 4; i++)
		begin
			wr(`DCFS_OFS_CTRL, i << 6 | i << 8 | i << 10 | i << 12 | 4, 2'h0);
			chg <= 1'b1;
			tstep(cl[i] - 1, 2'h0, "charge low trip");
			tstep(cl[i] + 5, 2'h1, "charge low exit");
			tstep(ch[i] + 1, 2'h0, "charge high trip");
			tstep(ch[i] - 5, 2'h1, "charge high exit");
			wr(`DCFS_OFS_CTRL, i << 6 | i << 8 | i << 10 | i << 12 | 5, 2'h0);
			chg <= 1'b0;
			tstep(dl[i] - 1, 2'h3, "discharge low trip");
			tstep(dl[i] + 5, 2'h1, "discharge low exit");
			tstep(dh[i] + 1, 2'h3, "discharge high trip");
			tstep(dh[i] - 5, 2'h1, "discharge high exit");
		end
		final_report();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("[FAIL] %0t run did not finish", $time);
		final_report();
	end
endmodule
